// >>> logic/sfph_consts.svh
`ifndef SFPH_CONSTS_SVH
`define SFPH_CONSTS_SVH

// Register byte addresses on the APB bus.
`define SFPH_ADDR_CTRL 12'h000
`define SFPH_ADDR_TX 12'h004
`define SFPH_ADDR_RX 12'h008
`define SFPH_ADDR_STAT 12'h00C

// Control register fields.
`define SFPH_CTRL_QE 0
`define SFPH_CTRL_FWCM 1
`define SFPH_CTRL_LINES_LO 2
`define SFPH_CTRL_LINES_HI 3
`define SFPH_CTRL_TURN_LO 8
`define SFPH_CTRL_TURN_HI 15
`define SFPH_CTRL_PFS 23

// Status register fields.
`define SFPH_STAT_FRAME 0
`define SFPH_STAT_PAUSE 1
`define SFPH_STAT_RSTSEEN 2
`define SFPH_STAT_WP 3
`define SFPH_STAT_CNT_LO 8
`define SFPH_STAT_CNT_HI 15

// Line mode encodings.
`define SFPH_LINES_SINGLE 2'h0
`define SFPH_LINES_DUAL 2'h1
`define SFPH_LINES_QUAD 2'h2

// Reset values and widths.
`define SFPH_TURN_RESET 8'h08
`define SFPH_ZERO_WORD 32'h0000_0000
`define SFPH_BITPOS_W 3

`endif

// >>> logic/sfph_pkg.sv
package sfph_pkg;
  // One serial byte.
  typedef logic [7:0] sfph_byte_t;
  // Count of active lanes per clock.
  typedef logic [2:0] sfph_lanes_t;
endpackage

// >>> logic/sfph_top.sv
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sfph_consts.svh"
// Function
// - Fourth pin pauses or resets per select bit.
// - Quad enable makes fourth pin data only.
// - Pause suspends without losing command progress.
// - Paused and selected keeps output high impedance.
// - Releasing pause resumes where it stopped.
// - Works with clock idle low or high.
// - Input data sampled on rising edge.
// - Output data changes on falling edge.
// - Dual uses lines zero and one bidirectionally.
// - Quad uses lines zero to three.
module sfph_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic data_line_0_i,
  output logic data_line_0_o,
  output logic data_line_0_oe,
  input wire logic data_line_1_i,
  output logic data_line_1_o,
  output logic data_line_1_oe,
  input wire logic data_line_2_i,
  output logic data_line_2_o,
  output logic data_line_2_oe,
  input wire logic data_line_3_i,
  output logic data_line_3_o,
  output logic data_line_3_oe
);

  // ==========================================================
  // Register bus
  // ==========================================================

  // Configuration and bus answer state.
  logic qe_r, qe_nxt;
  logic fwcm_r, fwcm_nxt;
  logic pfs_r, pfs_nxt;
  logic [1:0] lines_r, lines_nxt;
  logic [7:0] turn_r, turn_nxt;
  sfph_pkg::sfph_byte_t tx_r, tx_nxt;
  logic rst_seen_r, rst_seen_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  // Pin level synchronisers and the pin reset level.
  logic [2:0] s1_r, s2_r, s3_r;
  logic pinrst_r, pinrst_nxt;
  // Receive toggle synchroniser and captured byte.
  logic tg1_r, tg2_r, tg3_r;
  sfph_pkg::sfph_byte_t rxc_r, rxc_nxt;
  // Link side results read across the crossing.
  sfph_pkg::sfph_byte_t rx_hold_r;
  logic rx_tgl_r;

  // Setup and access phases of an APB transfer.
  logic setup, access;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;

  // Bus answer and register writes for the next cycle.
  always_comb begin
    qe_nxt = qe_r;
    fwcm_nxt = fwcm_r;
    pfs_nxt = pfs_r;
    lines_nxt = lines_r;
    turn_nxt = turn_r;
    tx_nxt = tx_r;
    rst_seen_nxt = rst_seen_r;
    prdata_nxt = prdata;
    pslverr_nxt = 1'b0;
    // Answer in the first access cycle.
    pready_nxt = setup;
    if (setup) begin
      prdata_nxt = `SFPH_ZERO_WORD;
      unique case (paddr)
        `SFPH_ADDR_CTRL: begin
          prdata_nxt[`SFPH_CTRL_QE] = qe_r;
          prdata_nxt[`SFPH_CTRL_FWCM] = fwcm_r;
          prdata_nxt[`SFPH_CTRL_LINES_HI:`SFPH_CTRL_LINES_LO] = lines_r;
          prdata_nxt[`SFPH_CTRL_TURN_HI:`SFPH_CTRL_TURN_LO] = turn_r;
          prdata_nxt[`SFPH_CTRL_PFS] = pfs_r;
        end
        `SFPH_ADDR_TX: begin
          prdata_nxt[7:0] = tx_r;
        end
        `SFPH_ADDR_RX: begin
          prdata_nxt[7:0] = rxc_r;
        end
        `SFPH_ADDR_STAT: begin
          prdata_nxt[`SFPH_STAT_FRAME] = ~s3_r[0];
          prdata_nxt[`SFPH_STAT_PAUSE] = ~s3_r[1] & ~qe_r & ~pfs_r;
          prdata_nxt[`SFPH_STAT_RSTSEEN] = rst_seen_r;
          prdata_nxt[`SFPH_STAT_WP] = s3_r[2];
          prdata_nxt[`SFPH_STAT_CNT_HI:`SFPH_STAT_CNT_LO] = cnt_r;
        end
        default: begin
          // Unmapped address answers with an error.
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      if (paddr == `SFPH_ADDR_CTRL) begin
        qe_nxt = pwdata[`SFPH_CTRL_QE];
        fwcm_nxt = pwdata[`SFPH_CTRL_FWCM];
        lines_nxt = pwdata[`SFPH_CTRL_LINES_HI:`SFPH_CTRL_LINES_LO];
        turn_nxt = pwdata[`SFPH_CTRL_TURN_HI:`SFPH_CTRL_TURN_LO];
        pfs_nxt = pwdata[`SFPH_CTRL_PFS];
      end else if (paddr == `SFPH_ADDR_TX) begin
        tx_nxt = pwdata[7:0];
      end else if (paddr == `SFPH_ADDR_STAT && pwdata[`SFPH_STAT_RSTSEEN]) begin
        rst_seen_nxt = 1'b0;
      end
    end
    // A pin reset in the same cycle as a clear keeps the flag set.
    if (pinrst_r) begin
      rst_seen_nxt = 1'b1;
    end
  end

  // Registers of the bus side.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qe_r <= 1'b0;
      fwcm_r <= 1'b0;
      pfs_r <= 1'b0;
      lines_r <= `SFPH_LINES_SINGLE;
      turn_r <= `SFPH_TURN_RESET;
      tx_r <= 8'h00;
      rst_seen_r <= 1'b0;
      prdata <= `SFPH_ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      qe_r <= qe_nxt;
      fwcm_r <= fwcm_nxt;
      pfs_r <= pfs_nxt;
      lines_r <= lines_nxt;
      turn_r <= turn_nxt;
      tx_r <= tx_nxt;
      rst_seen_r <= rst_seen_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================

  // Three stages for select, fourth pin and write protect.
  logic [2:0] pins_raw;
  assign pins_raw = {data_line_2_i, data_line_3_i, cs_n};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi] <= 1'b1;
          s2_r[gi] <= 1'b1;
          s3_r[gi] <= 1'b1;
        end else begin
          s1_r[gi] <= pins_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
        end
      end
    end
  endgenerate

  // Pin reset level and receive capture.
  always_comb begin
    pinrst_nxt = pinrst_r;
    if (pfs_r && !qe_r && s2_r[1] == s3_r[1]) begin
      pinrst_nxt = ~s3_r[1];
    end
    if (qe_r || !pfs_r) begin
      pinrst_nxt = 1'b0;
    end
    rxc_nxt = rxc_r;
    cnt_nxt = cnt_r;
    // A new byte from the link is taken on the toggle edge.
    if (tg2_r != tg3_r) begin
      rxc_nxt = rx_hold_r;
      cnt_nxt = cnt_r + 8'h01;
    end
    if (pinrst_r) begin
      cnt_nxt = 8'h00;
    end
  end

  // Registers of the receive crossing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinrst_r <= 1'b0;
      tg1_r <= 1'b0;
      tg2_r <= 1'b0;
      tg3_r <= 1'b0;
      rxc_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      pinrst_r <= pinrst_nxt;
      tg1_r <= rx_tgl_r;
      tg2_r <= tg1_r;
      tg3_r <= tg2_r;
      rxc_r <= rxc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Link side
  // ==========================================================

  // Frame reset and pause condition.
  logic link_rst_n, hold_now, kill_n;
  assign link_rst_n = presetn & ~cs_n & ~pinrst_r;
  assign hold_now = ~data_line_3_i & ~qe_r & ~pfs_r;
  assign kill_n = link_rst_n & ~hold_now;

  // Lanes per clock; quad needs the fourth pin as data.
  sfph_pkg::sfph_lanes_t lanes;
  logic quad;
  assign quad = qe_r & (fwcm_r | lines_r == `SFPH_LINES_QUAD);
  assign lanes = quad ? 3'd4 : (lines_r == `SFPH_LINES_DUAL ? 3'd2 : 3'd1);

  // Rising edge state: edge count, bit position, shift.
  logic [7:0] edge_r, edge_nxt;
  logic [`SFPH_BITPOS_W-1:0] ipos_r, ipos_nxt;
  sfph_pkg::sfph_byte_t ish_r, ish_nxt;
  sfph_pkg::sfph_byte_t rx_hold_nxt;
  logic rx_tgl_nxt;
  logic out_ph;
  assign out_ph = edge_r >= turn_r;

  // Input shifting computed for the next rising edge.
  always_comb begin
    edge_nxt = edge_r;
    ipos_nxt = ipos_r;
    ish_nxt = ish_r;
    rx_hold_nxt = rx_hold_r;
    rx_tgl_nxt = rx_tgl_r;
    if (!hold_now) begin
      if (edge_r != 8'hFF) begin
        edge_nxt = edge_r + 8'h01;
      end
      if (!out_ph) begin
        unique case (lanes)
          3'd4: ish_nxt = {ish_r[3:0], data_line_3_i, data_line_2_i,
                           data_line_1_i, data_line_0_i};
          3'd2: ish_nxt = {ish_r[5:0], data_line_1_i, data_line_0_i};
          default: ish_nxt = {ish_r[6:0], data_line_0_i};
        endcase
        ipos_nxt = ipos_r + lanes[`SFPH_BITPOS_W-1:0];
        if (ipos_nxt == '0) begin
          rx_hold_nxt = ish_nxt;
          rx_tgl_nxt = ~rx_tgl_r;
        end
      end
    end
  end

  // only edges matter, not idle level
  always_ff @(posedge link_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      edge_r <= 8'h00;
      ipos_r <= '0;
      ish_r <= 8'h00;
    end else begin
      edge_r <= edge_nxt;
      ipos_r <= ipos_nxt;
      ish_r <= ish_nxt;
    end
  end

  // Received byte and toggle survive the frame end for the bus side.
  always_ff @(posedge link_sclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end else begin
      rx_hold_r <= rx_hold_nxt;
      rx_tgl_r <= rx_tgl_nxt;
    end
  end

  // Falling edge state: output shift and position.
  logic [`SFPH_BITPOS_W-1:0] opos_r, opos_nxt;
  sfph_pkg::sfph_byte_t osh_r, osh_nxt;
  logic [3:0] dout_nxt, oe_nxt;

  // Output shifting computed for the next falling edge.
  always_comb begin
    opos_nxt = opos_r;
    osh_nxt = osh_r;
    dout_nxt = {data_line_3_o, data_line_2_o, data_line_1_o, data_line_0_o};
    oe_nxt = 4'h0;
    if (out_ph) begin
      osh_nxt = (opos_r == '0) ? tx_r : (osh_r << lanes);
      opos_nxt = opos_r + lanes[`SFPH_BITPOS_W-1:0];
      unique case (lanes)
        3'd4: begin
          dout_nxt = osh_nxt[7:4];
          oe_nxt = 4'hF;
        end
        3'd2: begin
          dout_nxt = {2'b00, osh_nxt[7:6]};
          oe_nxt = 4'h3;
        end
        default: begin
          dout_nxt = {2'b00, osh_nxt[7], 1'b0};
          oe_nxt = 4'h2;
        end
      endcase
    end
    if (hold_now) begin
      opos_nxt = opos_r;
      osh_nxt = osh_r;
      dout_nxt = {data_line_3_o, data_line_2_o, data_line_1_o, data_line_0_o};
    end
  end

  always_ff @(negedge link_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      opos_r <= '0;
      osh_r <= 8'h00;
      data_line_0_o <= 1'b0;
      data_line_1_o <= 1'b0;
      data_line_2_o <= 1'b0;
      data_line_3_o <= 1'b0;
    end else begin
      opos_r <= opos_nxt;
      osh_r <= osh_nxt;
      data_line_0_o <= dout_nxt[0];
      data_line_1_o <= dout_nxt[1];
      data_line_2_o <= dout_nxt[2];
      data_line_3_o <= dout_nxt[3];
    end
  end

  // enables cleared at once by pause or select high
  always_ff @(negedge link_sclk or negedge kill_n) begin
    if (!kill_n) begin
      data_line_0_oe <= 1'b0;
      data_line_1_oe <= 1'b0;
      data_line_2_oe <= 1'b0;
      data_line_3_oe <= 1'b0;
    end else begin
      data_line_0_oe <= oe_nxt[0];
      data_line_1_oe <= oe_nxt[1];
      data_line_2_oe <= oe_nxt[2];
      data_line_3_oe <= oe_nxt[3];
    end
  end

endmodule

// >>> verif/sfph_properties.sv
`timescale 1ns/1ps
`include "sfph_consts.svh"
// ==========
// Checker on the top-level ports.
module sfph_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic data_line_0_i,
  input wire logic data_line_0_o,
  input wire logic data_line_0_oe,
  input wire logic data_line_1_i,
  input wire logic data_line_1_o,
  input wire logic data_line_1_oe,
  input wire logic data_line_2_i,
  input wire logic data_line_2_o,
  input wire logic data_line_2_oe,
  input wire logic data_line_3_i,
  input wire logic data_line_3_o,
  input wire logic data_line_3_oe
);
  logic [31:0] ctrl_r; // Shadow of the control word.
  logic [31:0] ctrl_nxt; // Next shadow value.
  // Follows completed control writes.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (psel && penable && pready && pwrite && paddr == `SFPH_ADDR_CTRL) begin
      ctrl_nxt = pwdata;
    end
  end
  // Registers the shadow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h0000_0800;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_paused;
    !cs_n && !data_line_3_i && !ctrl_r[0] && !ctrl_r[23];
  endsequence
  AST_READY: assert property (s_setup |=> pready)
    else $error("no ready in access cycle");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (s_setup ##0 paddr > `SFPH_ADDR_STAT |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_CS_RELEASE: assert property (cs_n |-> !(data_line_0_oe || data_line_1_oe || data_line_2_oe || data_line_3_oe))
    else $error("line driven while deselected");
  AST_PAUSE_HIZ: assert property (s_paused |-> !data_line_1_oe && !data_line_0_oe)
    else $error("output driven in pause");
  AST_PIN3_IN: assert property (!ctrl_r[0] |-> !data_line_3_oe && !data_line_2_oe)
    else $error("upper lines driven without quad");
  AST_SINGLE_IN: assert property (!ctrl_r[1] && ctrl_r[3:2] == 2'h0 |-> !data_line_0_oe)
    else $error("input line driven in single mode");
  AST_OUT_EDGE: assert property (!cs_n && !$past(cs_n) && $changed(data_line_1_o) |-> !link_sclk)
    else $error("output changed off falling edge");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

// >>> verif/sfph_master_model.sv
`timescale 1ns/1ps
// ==========
// Serial bus master: makes the link clock and frames transfers.
module sfph_master_model (
  output logic link_sclk,
  output logic cs_n,
  output logic [3:0] m_o,
  output logic [3:0] m_oe,
  input wire logic [3:0] ln
);
  // Idle: deselected, protect and pause pins held high.
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    m_o = 4'hF;
    m_oe = 4'hF;
  end
  // Sets the fourth pin while deselected.
  task pin3(input logic v);
    m_o[3] = v;
  endtask
  // One frame: input byte, then output edges, optional pause.
  task frame(input logic m3, input int lanes, input logic [7:0] din, input int turn, input int nedge,
             input int pause_at, output logic [7:0] dout);
    logic [7:0] sh;
    sh = din;
    dout = 8'h00;
    #1;
    // idle clock level, settled before select so no edge races it
    link_sclk = m3;
    #32;
    cs_n = 1'b0;
    #32;
    link_sclk = 1'b0;
    for (int k = 0; k < nedge; k++) begin
      if (k < turn) begin
        case (lanes)
          1: m_o[0] = sh[7];
          2: m_o[1:0] = sh[7:6];
          default: m_o = sh[7:4];
        endcase
        sh = sh << lanes;
      end else begin
        m_oe = (lanes == 4) ? 4'h0 : 4'hC;
      end
      #32;
      // Output bits are taken just before the rising edge.
      if (k >= turn) begin
        case (lanes)
          1: dout = {dout[6:0], ln[1]};
          2: dout = {dout[5:0], ln[1:0]};
          default: dout = {dout[3:0], ln};
        endcase
      end
      link_sclk = 1'b1;
      // pause with the clock high, one ignored pulse, then resume
      if (k == pause_at) begin
        #16;
        m_o[3] = 1'b0;
        #16;
        link_sclk = 1'b0;
        #32;
        link_sclk = 1'b1;
        #16;
        // Release lands with the clock high, so the enables return at the next falling edge.
        m_o[3] = 1'b1;
      end
      #32;
      link_sclk = 1'b0;
    end
    #32;
    link_sclk = m3;
    #32;
    cs_n = 1'b1;
    m_o = 4'hF;
    m_oe = 4'hF;
  endtask
endmodule

// >>> verif/sfph_tb.sv
`timescale 1ns/1ps
`include "sfph_consts.svh"
bind sfph_top sfph_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_sclk(link_sclk), .cs_n(cs_n), .data_line_0_i(data_line_0_i), .data_line_0_o(data_line_0_o),
  .data_line_0_oe(data_line_0_oe), .data_line_1_i(data_line_1_i), .data_line_1_o(data_line_1_o),
  .data_line_1_oe(data_line_1_oe), .data_line_2_i(data_line_2_i), .data_line_2_o(data_line_2_o),
  .data_line_2_oe(data_line_2_oe), .data_line_3_i(data_line_3_i), .data_line_3_o(data_line_3_o),
  .data_line_3_oe(data_line_3_oe));
// ==========
// Bench: APB tasks and link frames.
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_sclk, cs_n, tgl, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] m_o, m_oe, doe, dq, ln;
  logic [7:0] d;
  int fail_count, n_tests, cyc, exp_cnt;
  // Wire level; an undriven line toggles.
  assign ln = (doe & dq) | (~doe & m_oe & m_o) | (~doe & ~m_oe & {4{tgl}});
  sfph_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sclk(link_sclk), .cs_n(cs_n), .data_line_0_i(ln[0]), .data_line_0_o(dq[0]),
    .data_line_0_oe(doe[0]), .data_line_1_i(ln[1]), .data_line_1_o(dq[1]), .data_line_1_oe(doe[1]),
    .data_line_2_i(ln[2]), .data_line_2_o(dq[2]), .data_line_2_oe(doe[2]), .data_line_3_i(ln[3]),
    .data_line_3_o(dq[3]), .data_line_3_oe(doe[3]));
  sfph_master_model mst (.link_sclk(link_sclk), .cs_n(cs_n), .m_o(m_o), .m_oe(m_oe), .ln(ln));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Toggles the pattern and cuts a hang short.
  always @(posedge pclk) begin
    tgl <= ~tgl;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One APB transfer; waits for ready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask
  // Frame with a full byte each way, then result checks.
  task xfer(input logic m3, input int lanes, input logic [7:0] din, tx, input int turn, pa);
    apb(1'b1, `SFPH_ADDR_TX, {24'h0, tx});
    mst.frame(m3, lanes, din, turn, turn + 8 / lanes, pa, d);
    exp_cnt++;
    chk("tx byte", {24'h0, tx}, {24'h0, d});
    repeat (8) @(posedge pclk);
    rd(`SFPH_ADDR_RX, {24'h0, din}, "rx byte");
    rd(`SFPH_ADDR_STAT, {16'h0, exp_cnt[7:0], 8'h08}, "status");
  endtask
  initial begin
    {psel, penable, pwrite, tgl, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SFPH_ADDR_CTRL, 32'h0000_0800, "ctrl reset");
    rd(`SFPH_ADDR_STAT, 32'h0000_0008, "status reset");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, `SFPH_ADDR_RX, 32'h0000_00FF);
    rd(`SFPH_ADDR_RX, 32'h0, "rx read only");
    $display("test reset done");
    for (int m = 0; m < 2; m++) xfer(m[0], 1, 8'h3C, 8'hA5, 8, -1);
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0000_0404);
    xfer(1'b0, 2, 8'h5A, 8'h96, 4, -1);
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0000_0209);
    xfer(1'b1, 4, 8'hC3, 8'h7E, 2, -1);
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0000_0203);
    xfer(1'b0, 4, 8'h81, 8'h18, 2, -1);
    $display("test lanes done");
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0000_0800);
    xfer(1'b0, 1, 8'h6D, 8'hB2, 8, 3);
    xfer(1'b1, 1, 8'h27, 8'hE4, 8, 11);
    $display("test pause done");
    mst.frame(1'b0, 1, 8'hFF, 8, 5, -1, d);
    repeat (8) @(posedge pclk);
    rd(`SFPH_ADDR_RX, 32'h0000_0027, "rx after abort");
    rd(`SFPH_ADDR_STAT, {16'h0, exp_cnt[7:0], 8'h08}, "count after abort");
    $display("test abort done");
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0080_0801);
    xfer(1'b0, 1, 8'h42, 8'h24, 8, -1);
    mst.pin3(1'b0);
    repeat (8) @(posedge pclk);
    mst.pin3(1'b1);
    rd(`SFPH_ADDR_STAT, {16'h0, exp_cnt[7:0], 8'h08}, "no pin reset");
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0080_0800);
    mst.pin3(1'b0);
    repeat (8) @(posedge pclk);
    mst.pin3(1'b1);
    rd(`SFPH_ADDR_STAT, 32'h0000_000C, "pin reset");
    apb(1'b1, `SFPH_ADDR_STAT, 32'h0000_0004);
    rd(`SFPH_ADDR_STAT, 32'h0000_0008, "reset flag clear");
    apb(1'b1, `SFPH_ADDR_CTRL, 32'h0000_0800);
    mst.pin3(1'b0);
    repeat (8) @(posedge pclk);
    rd(`SFPH_ADDR_STAT, 32'h0000_000A, "pause status");
    mst.pin3(1'b1);
    $display("test pin done");
    complete_run();
  end
endmodule
